// ==== cmp_pkg.sv ====
// Constants, register map and types of the comparator and DAC control block.
// Assumes an AHB-Lite slave with 32-bit data and one register per aligned word.
package cmp_pkg;
	// Register indices; a register's byte address is four times its index
	localparam logic [7:0] STATUS_CTRL_ADDR = 8'h2C;
	localparam logic [7:0] INPUT_SEL_ADDR   = 8'h2D;
	localparam logic [7:0] DAC_CTRL_ADDR    = 8'h2E;
	localparam logic [7:0] PIN_ALLOW_ADDR   = 8'h2F;
	localparam int         ADDR_BITS        = 8;
	// Field positions in status_ctrl
	localparam int COMP_ON_BIT    = 7;
	localparam int FLAG_BIT       = 5;
	localparam int IRQ_EN_BIT     = 4;
	localparam int STATUS_BIT     = 3;
	localparam int OUT_ALLOW_BIT  = 2;
	// Field positions and level width in dac_control, and the analog pin count
	localparam int DAC_ON_BIT     = 7;
	localparam int DAC_REF_BIT    = 6;
	localparam int DAC_LEVEL_BITS = 6;
	localparam int PIN_COUNT      = 3;
	// Reset values and synchroniser depth
	localparam logic [7:0] STATUS_CTRL_RESET = 8'h00;
	localparam logic [7:0] INPUT_SEL_RESET   = 8'h00;
	localparam logic [7:0] DAC_CTRL_RESET    = 8'h00;
	localparam logic [7:0] PIN_ALLOW_RESET   = 8'h00;
	localparam int         SYNC_STAGES       = 2;
	typedef enum logic [1:0]
	{
		SEL_EXT0,
		SEL_EXT1,
		SEL_RSVD,
		SEL_DAC
	} input_sel_t;
	typedef enum logic [1:0]
	{
		EDGE_FALL0,
		EDGE_RISE,
		EDGE_FALL1,
		EDGE_BOTH
	} edge_mode_t;
endpackage

// ==== edge_if.sv ====
// Carries the synchronised comparator result and edge events between modules.
// Assumes a single bus clock domain.
`timescale 1ns/1ps
interface edge_if;
	logic level;
	logic rise;
	logic fall;
	modport src (output level, output rise, output fall);
	modport dst (input level, input rise, input fall);
endinterface

// ==== cmp_edge_sync.sv ====
// Two-stage synchroniser and edge detector for the raw comparator output.
// Assumes the raw output is asynchronous to CLK_I.
`timescale 1ns/1ps
module cmp_edge_sync
	import cmp_pkg::*;
(
	input  wire logic clk_i,    // Bus clock
	input  wire logic arst_n_i, // Async reset, low
	input  wire logic enable_i, // Comparator on
	input  wire logic raw_i,    // Raw comparator output
	edge_if.src       ev        // Synchronised level and edges
);
	logic meta_reg;
	logic meta_next;
	logic sync_reg;
	logic sync_next;
	logic last_reg;
	logic last_next;

	always_comb
	begin
		meta_next = raw_i;
		sync_next = meta_reg;
		// Held at zero while off so a high input shows as a rise on enabling
		last_next = enable_i ? sync_reg : 1'b0;
	end

	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			meta_reg <= 1'b0;
			sync_reg <= 1'b0;
			last_reg <= 1'b0;
		end
		else
		begin
			meta_reg <= meta_next;
			sync_reg <= sync_next;
			last_reg <= last_next;
		end
	end

	assign ev.level = enable_i & last_reg;
	assign ev.rise  = enable_i & sync_reg & ~last_reg;
	assign ev.fall  = enable_i & ~sync_reg & last_reg;
endmodule

// ==== comparator_dac_control.sv ====
// AHB-Lite register slave and control logic of the comparator and DAC.
// Assumes an analog macro that drives the raw result and obeys the control outputs.
//
// Design decision made here: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module comparator_dac_control
	import cmp_pkg::*;
(
	input  wire logic                          CLK_I,          // Bus clock
	input  wire logic                          ARST_N_I,       // Async reset, low
	input  wire logic                          HSEL_I,         // Slave select
	input  wire logic [31:0]                   HADDR_I,        // Address
	input  wire logic [1:0]                    HTRANS_I,       // Transfer type
	input  wire logic                          HWRITE_I,       // Write
	input  wire logic [2:0]                    HSIZE_I,        // Size
	input  wire logic [31:0]                   HWDATA_I,       // Write data
	input  wire logic                          HREADY_I,       // Bus ready
	output logic      [31:0]                   HRDATA_O,       // Read data
	output logic                               HREADYOUT_O,    // Slave ready
	output logic                               HRESP_O,        // Response
	input  wire logic                          DEEP_STOP_I,    // Bus clock stopped
	input  wire logic                          RAW_CMP_I,      // Raw comparator output
	output logic                               COMP_ON_O,      // Comparator enable
	output logic      [1:0]                    POS_SEL_O,      // Positive input select
	output logic      [1:0]                    NEG_SEL_O,      // Negative input select
	output logic                               DAC_ON_O,       // DAC enable
	output logic                               DAC_REF_O,      // DAC reference select
	output logic      [cmp_pkg::DAC_LEVEL_BITS-1:0] DAC_LEVEL_O, // DAC level code
	output logic                               DAC_EXPORT_O,   // DAC output routed out
	output logic      [cmp_pkg::PIN_COUNT-1:0] PIN_ALLOW_O,    // Analog pin enables
	output logic                               OUT_PIN_O,      // Comparator pin data
	output logic                               OUT_PIN_OE_O,   // Comparator pin enable
	output logic                               IRQ_O,          // Interrupt request
	output logic                               WAKE_O          // Async wake request
);
	import cmp_pkg::*;

	logic [7:0]       status_reg;
	logic [7:0]       status_next;
	logic [7:0]       insel_reg;
	logic [7:0]       insel_next;
	logic [7:0]       dacc_reg;
	logic [7:0]       dacc_next;
	logic [PIN_COUNT-1:0] pins_reg;
	logic [PIN_COUNT-1:0] pins_next;
	logic             wr_pend_reg;
	logic             wr_pend_next;
	logic [ADDR_BITS-1:0] wr_addr_reg;
	logic [ADDR_BITS-1:0] wr_addr_next;
	logic [31:0]      rdata_reg;
	logic [31:0]      rdata_next;
	logic             wake_reg;
	logic             wake_next;
	logic             access;
	logic [ADDR_BITS-1:0] a_addr;
	logic             valid_edge;
	logic             comp_on;
	logic [1:0]       edge_mode;
	logic [7:0]       wbyte;
	logic [7:0]       status_read;
	logic             raw_edge;
	logic             raw_last_reg;

	edge_if ev();

	cmp_edge_sync u_sync
	(
		.clk_i    (CLK_I),
		.arst_n_i (ARST_N_I),
		.enable_i (comp_on),
		.raw_i    (RAW_CMP_I),
		.ev       (ev)
	);

	assign comp_on   = status_reg[COMP_ON_BIT];
	assign edge_mode = status_reg[1:0];
	assign access    = HSEL_I & HREADY_I & HTRANS_I[1];
	// Word index: one register per aligned 32-bit word
	assign a_addr    = HADDR_I[ADDR_BITS+1:2];
	assign wbyte     = HWDATA_I[7:0];

	always_comb
	begin
		case (edge_mode_t'(edge_mode))
			EDGE_FALL0: valid_edge = ev.fall;
			EDGE_FALL1: valid_edge = ev.fall;
			EDGE_RISE:  valid_edge = ev.rise;
			EDGE_BOTH:  valid_edge = ev.rise | ev.fall;
			default:    valid_edge = 1'b0;
		endcase
	end

	always_comb
	begin
		status_read = status_reg;
		status_read[STATUS_BIT] = ev.level;
	end

	// Registers sit in byte lane 0 of each word
	always_comb
	begin
		status_next  = status_reg;
		insel_next   = insel_reg;
		dacc_next    = dacc_reg;
		pins_next    = pins_reg;
		wr_pend_next = access & HWRITE_I;
		wr_addr_next = access ? a_addr : wr_addr_reg;
		rdata_next   = rdata_reg;
		if (wr_pend_reg)
		begin
			case (wr_addr_reg)
				STATUS_CTRL_ADDR:
				begin
					status_next[COMP_ON_BIT]   = wbyte[COMP_ON_BIT];
					status_next[6]             = wbyte[6];
					status_next[IRQ_EN_BIT]    = wbyte[IRQ_EN_BIT];
					status_next[OUT_ALLOW_BIT] = wbyte[OUT_ALLOW_BIT];
					status_next[1:0]           = wbyte[1:0];
					if (!wbyte[FLAG_BIT])
						status_next[FLAG_BIT] = 1'b0;
				end
				INPUT_SEL_ADDR:
					insel_next = {2'b00, wbyte[5:4], 2'b00, wbyte[1:0]};
				DAC_CTRL_ADDR:
					dacc_next = wbyte;
				PIN_ALLOW_ADDR:
					pins_next = wbyte[PIN_COUNT-1:0];
				default:
					status_next = status_next;
			endcase
		end
		// Hardware set wins over a clear in the same cycle
		if (comp_on & valid_edge)
			status_next[FLAG_BIT] = 1'b1;
		status_next[STATUS_BIT] = 1'b0;
		if (access & !HWRITE_I)
		begin
			case (a_addr)
				STATUS_CTRL_ADDR: rdata_next = {24'h000000, status_read};
				INPUT_SEL_ADDR:   rdata_next = {24'h000000, insel_reg};
				DAC_CTRL_ADDR:    rdata_next = {24'h000000, dacc_reg};
				PIN_ALLOW_ADDR:   rdata_next = {29'h00000000, pins_reg};
				default:          rdata_next = 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge CLK_I or negedge ARST_N_I)
	begin
		if (!ARST_N_I)
		begin
			status_reg  <= STATUS_CTRL_RESET;
			insel_reg   <= INPUT_SEL_RESET;
			dacc_reg    <= DAC_CTRL_RESET;
			pins_reg    <= PIN_ALLOW_RESET[PIN_COUNT-1:0];
			wr_pend_reg <= 1'b0;
			wr_addr_reg <= 8'h00;
			rdata_reg   <= 32'h00000000;
		end
		else
		begin
			status_reg  <= status_next;
			insel_reg   <= insel_next;
			dacc_reg    <= dacc_next;
			pins_reg    <= pins_next;
			wr_pend_reg <= wr_pend_next;
			wr_addr_reg <= wr_addr_next;
			rdata_reg   <= rdata_next;
		end
	end

	// Deep stop wake path: runs on the raw output edge, no bus clock needed
	always_ff @(posedge CLK_I or negedge ARST_N_I)
	begin
		if (!ARST_N_I)
			raw_last_reg <= 1'b0;
		else
			raw_last_reg <= ev.level;
	end

	always_comb
	begin
		case (edge_mode_t'(edge_mode))
			EDGE_RISE: raw_edge = RAW_CMP_I & ~raw_last_reg;
			EDGE_BOTH: raw_edge = RAW_CMP_I ^ raw_last_reg;
			default:   raw_edge = ~RAW_CMP_I & raw_last_reg;
		endcase
		// Latched request drops on the first clock edge with DEEP_STOP_I low
		wake_next = wake_reg | raw_edge;
	end

	always_ff @(posedge CLK_I or negedge ARST_N_I)
	begin
		if (!ARST_N_I)
			wake_reg <= 1'b0;
		else
			wake_reg <= wake_next & DEEP_STOP_I;
	end

	// Combinational while stopped: the raw edge versus the last seen level
	assign WAKE_O = DEEP_STOP_I & comp_on & status_reg[IRQ_EN_BIT] & (raw_edge | wake_reg);

	assign HRDATA_O     = rdata_reg;
	assign HREADYOUT_O  = 1'b1;
	assign HRESP_O      = 1'b0;
	assign COMP_ON_O    = comp_on;
	assign POS_SEL_O    = insel_reg[5:4];
	assign NEG_SEL_O    = insel_reg[1:0];
	assign DAC_ON_O     = dacc_reg[DAC_ON_BIT];
	assign DAC_REF_O    = dacc_reg[DAC_REF_BIT];
	assign DAC_LEVEL_O  = dacc_reg[DAC_LEVEL_BITS-1:0];
	assign DAC_EXPORT_O = dacc_reg[DAC_ON_BIT];
	assign PIN_ALLOW_O  = pins_reg;
	assign OUT_PIN_O    = ev.level;
	assign OUT_PIN_OE_O = status_reg[OUT_ALLOW_BIT] & comp_on;
	assign IRQ_O        = status_reg[FLAG_BIT] & status_reg[IRQ_EN_BIT];
endmodule

// ==== cmp_analog_model.sv ====
// Behavioural analog comparator and DAC that sit beside the control block.
// Assumes levels in steps of one sixty-fourth of the DAC reference.
`timescale 1ns/1ps
module cmp_analog_model
(
	input  wire logic       dac_on_i,    // DAC enable
	input  wire logic [5:0] dac_level_i, // DAC code
	input  wire logic [2:0] pin_allow_i, // Pad input enables
	input  wire logic [1:0] pos_sel_i,   // Positive select
	input  wire logic [1:0] neg_sel_i,   // Negative select
	input  wire logic [6:0] ext0_i,      // External input 0 level
	input  wire logic [6:0] ext1_i,      // External input 1 level
	output logic            raw_o        // Comparator result
);
	function automatic logic [6:0] pick(input logic [1:0] s);
		case (s)
			2'h0: pick = pin_allow_i[0] ? ext0_i : 7'h00;
			2'h1: pick = pin_allow_i[1] ? ext1_i : 7'h00;
			2'h3: pick = dac_on_i ? {1'b0, dac_level_i} + 7'h01 : 7'h00;
			default: pick = 7'h00;
		endcase
	endfunction
	always_comb
		raw_o = pick(pos_sel_i) > pick(neg_sel_i);
endmodule

// ==== cda_chk.sv ====
// Assertions on the ports of the comparator and DAC control block.
// Assumes one clock domain and a zero-wait register slave.
`timescale 1ns/1ps
module cda_chk
	import cmp_pkg::*;
(
	input wire logic        CLK_I,        // Bus clock
	input wire logic        ARST_N_I,     // Async reset, low
	input wire logic        HSEL_I,       // Slave select
	input wire logic [31:0] HADDR_I,      // Address
	input wire logic [1:0]  HTRANS_I,     // Transfer type
	input wire logic        HWRITE_I,     // Write
	input wire logic [31:0] HWDATA_I,     // Write data
	input wire logic        HREADY_I,     // Bus ready
	input wire logic        HREADYOUT_O,  // Slave ready
	input wire logic        HRESP_O,      // Response
	input wire logic        DEEP_STOP_I,  // Clock stopped
	input wire logic        RAW_CMP_I,    // Raw result
	input wire logic        COMP_ON_O,    // Comparator enable
	input wire logic [1:0]  POS_SEL_O,    // Positive select
	input wire logic [1:0]  NEG_SEL_O,    // Negative select
	input wire logic        DAC_ON_O,     // DAC enable
	input wire logic        DAC_REF_O,    // DAC reference
	input wire logic [5:0]  DAC_LEVEL_O,  // DAC code
	input wire logic        DAC_EXPORT_O, // DAC routed out
	input wire logic [2:0]  PIN_ALLOW_O,  // Pad enables
	input wire logic        OUT_PIN_O,    // Pin data
	input wire logic        OUT_PIN_OE_O, // Pin enable
	input wire logic        WAKE_O        // Wake request
);
	default clocking @(posedge CLK_I); endclocking
	default disable iff (!ARST_N_I);
	logic       wr;
	logic [7:0] wb;
	logic       w_on;
	logic       w_oe;
	assign wr = HSEL_I && HREADY_I && HTRANS_I[1] && HWRITE_I;
	assign wb = HWDATA_I[7:0];
	assign w_on = HWDATA_I[7];
	assign w_oe = HWDATA_I[7] & HWDATA_I[2];
	a_bus_okay: assert property (HREADYOUT_O && !HRESP_O)
		else $error("bus not ready or error");
	a_dac_write: assert property (wr && HADDR_I[ADDR_BITS+1:2] == DAC_CTRL_ADDR
		|=> ##1 {DAC_ON_O, DAC_REF_O, DAC_LEVEL_O} == $past(wb)) else $error("dac write lost");
	a_sel_write: assert property (wr && HADDR_I[ADDR_BITS+1:2] == INPUT_SEL_ADDR
		|=> ##1 {2'h0, POS_SEL_O, 2'h0, NEG_SEL_O} == ($past(wb) & 8'h33))
		else $error("select write lost");
	a_pin_write: assert property (wr && HADDR_I[ADDR_BITS+1:2] == PIN_ALLOW_ADDR
		|=> ##1 {5'h00, PIN_ALLOW_O} == ($past(wb) & 8'h07)) else $error("pin write lost");
	a_status_write: assert property (wr && HADDR_I[ADDR_BITS+1:2] == STATUS_CTRL_ADDR
		|=> ##1 COMP_ON_O == $past(w_on) && OUT_PIN_OE_O == $past(w_oe))
		else $error("status write lost");
	a_export_dac: assert property (DAC_EXPORT_O == DAC_ON_O)
		else $error("dac export wrong");
	a_off_no_pin: assert property (!COMP_ON_O |-> !OUT_PIN_OE_O)
		else $error("pin driven while off");
	a_track_raw: assert property ((COMP_ON_O && $stable(RAW_CMP_I))[*6]
		|-> OUT_PIN_O == RAW_CMP_I) else $error("output not tracking");
	a_off_zero: assert property ((!COMP_ON_O)[*4] |-> !OUT_PIN_O)
		else $error("output high while off");
	a_wake_stop: assert property (!DEEP_STOP_I |-> !WAKE_O)
		else $error("wake outside deep stop");
	a_reset_off: assert property ($rose(ARST_N_I) |-> !COMP_ON_O && !DAC_ON_O)
		else $error("enabled after reset");
endmodule
bind comparator_dac_control cda_chk i_cda_chk (.CLK_I(CLK_I), .ARST_N_I(ARST_N_I),
	.HSEL_I(HSEL_I), .HADDR_I(HADDR_I), .HTRANS_I(HTRANS_I), .HWRITE_I(HWRITE_I),
	.HWDATA_I(HWDATA_I), .HREADY_I(HREADY_I), .HREADYOUT_O(HREADYOUT_O), .HRESP_O(HRESP_O),
	.DEEP_STOP_I(DEEP_STOP_I), .RAW_CMP_I(RAW_CMP_I), .COMP_ON_O(COMP_ON_O),
	.POS_SEL_O(POS_SEL_O), .NEG_SEL_O(NEG_SEL_O), .DAC_ON_O(DAC_ON_O), .DAC_REF_O(DAC_REF_O),
	.DAC_LEVEL_O(DAC_LEVEL_O), .DAC_EXPORT_O(DAC_EXPORT_O), .PIN_ALLOW_O(PIN_ALLOW_O),
	.OUT_PIN_O(OUT_PIN_O), .OUT_PIN_OE_O(OUT_PIN_OE_O), .WAKE_O(WAKE_O));

// ==== tb.sv ====
// Self-checking bench: registers, edge modes, flag, wake and disable.
// Assumes the zero-wait slave of the block and the analog model beside it.
`timescale 1ns/1ps
module tb;
	import cmp_pkg::*;
	logic        clk, arst_n, hsel, hwrite, deep_stop, hready, hresp, raw;
	logic        comp_on, dac_on, dac_ref, dac_export, oe, out_pin, irq, wake;
	logic [31:0] haddr, hwdata, hrdata;
	logic [1:0]  htrans, pos_sel, neg_sel;
	logic [6:0]  ext0;
	logic [5:0]  dac_level;
	logic [2:0]  pin_allow;
	logic [7:0]  st;
	int          miscompares, samples_checked;
	comparator_dac_control i_comparator_dac_control (.CLK_I(clk), .ARST_N_I(arst_n),
		.HSEL_I(hsel), .HADDR_I(haddr), .HTRANS_I(htrans), .HWRITE_I(hwrite),
		.HSIZE_I(3'h2), .HWDATA_I(hwdata), .HREADY_I(hready), .HRDATA_O(hrdata),
		.HREADYOUT_O(hready), .HRESP_O(hresp), .DEEP_STOP_I(deep_stop), .RAW_CMP_I(raw),
		.COMP_ON_O(comp_on), .POS_SEL_O(pos_sel), .NEG_SEL_O(neg_sel), .DAC_ON_O(dac_on),
		.DAC_REF_O(dac_ref), .DAC_LEVEL_O(dac_level), .DAC_EXPORT_O(dac_export),
		.PIN_ALLOW_O(pin_allow), .OUT_PIN_O(out_pin), .OUT_PIN_OE_O(oe), .IRQ_O(irq),
		.WAKE_O(wake));
	cmp_analog_model i_cmp_analog_model (.dac_on_i(dac_on), .dac_level_i(dac_level),
		.pin_allow_i(pin_allow), .pos_sel_i(pos_sel), .neg_sel_i(neg_sel), .ext0_i(ext0),
		.ext1_i(7'h0A), .raw_o(raw));
	always #2.5 clk = ~clk;
	task automatic end_of_test;
		if (miscompares == 0 && samples_checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wait_rdy;
		int n;
		n = 0;
		@(posedge clk);
		while (hready !== 1'b1)
		begin
			n++;
			if (n > 50)
			begin
				miscompares++;
				end_of_test();
			end
			@(posedge clk);
		end
	endtask
	task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] d);
		hsel <= 1'b1;
		haddr <= {22'h0, a, 2'b00};
		htrans <= 2'h2;
		hwrite <= wr;
		wait_rdy();
		htrans <= 2'h0;
		hwdata <= {24'h0, d};
		wait_rdy();
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		xfer(1'b0, a, 8'h00);
		chk(hrdata, {24'h0, e});
	endtask
	initial
	begin
		clk = 1'b0; arst_n = 1'b0; hsel = 1'b0; haddr = 32'h0; htrans = 2'h0;
		hwrite = 1'b0; hwdata = 32'h0; deep_stop = 1'b0; ext0 = 7'h28;
		miscompares = 0; samples_checked = 0;
		repeat (4) @(posedge clk);
		arst_n <= 1'b1;
		@(posedge clk);
		chk({24'h0, comp_on, dac_on, irq, wake, oe, out_pin, dac_export, 1'b0}, 32'h0);
		for (int i = 0; i < 5; i++)
			rd(STATUS_CTRL_ADDR + 8'(i), 8'h00);
		xfer(1'b1, PIN_ALLOW_ADDR, 8'hFF);
		rd(PIN_ALLOW_ADDR, 8'h07);
		xfer(1'b1, INPUT_SEL_ADDR, 8'hFF);
		rd(INPUT_SEL_ADDR, 8'h33);
		xfer(1'b1, INPUT_SEL_ADDR, 8'h30);
		xfer(1'b1, DAC_CTRL_ADDR, 8'h5F);
		rd(DAC_CTRL_ADDR, 8'h5F);
		chk({24'h0, dac_on, dac_ref, dac_level}, 32'h5F);
		xfer(1'b1, DAC_CTRL_ADDR, 8'h9F);
		@(posedge clk);
		chk({23'h0, dac_export, pos_sel, neg_sel, pin_allow, dac_on}, 32'h1CF);
		for (int m = 0; m < 4; m++)
		begin
			st = 8'h94 | 8'(m);
			xfer(1'b1, STATUS_CTRL_ADDR, st);
			ext0 <= 7'h14;
			repeat (8) @(posedge clk);
			rd(STATUS_CTRL_ADDR, st | 8'h08 | (m[0] ? 8'h20 : 8'h00));
			chk({30'h0, irq, oe & out_pin}, {30'h0, m[0], 1'b1});
			xfer(1'b1, STATUS_CTRL_ADDR, st);
			ext0 <= 7'h28;
			repeat (8) @(posedge clk);
			rd(STATUS_CTRL_ADDR, st | ((m != 1) ? 8'h20 : 8'h00));
			chk({31'h0, irq}, {31'h0, m != 1});
		end
		xfer(1'b1, STATUS_CTRL_ADDR, 8'hB7);
		rd(STATUS_CTRL_ADDR, 8'hB7);
		xfer(1'b1, STATUS_CTRL_ADDR, 8'h93);
		deep_stop <= 1'b1;
		ext0 <= 7'h14;
		@(posedge clk);
		#1;
		chk({31'h0, wake}, 32'h1);
		@(posedge clk);
		deep_stop <= 1'b0;
		repeat (8) @(posedge clk);
		rd(STATUS_CTRL_ADDR, 8'hBB);
		xfer(1'b1, STATUS_CTRL_ADDR, 8'h04);
		rd(STATUS_CTRL_ADDR, 8'h04);
		chk({30'h0, oe, out_pin}, 32'h0);
		end_of_test();
	end
endmodule
